// >>> nvsram_host_cfg.svh
// Purpose: Constants for the nonvolatile SRAM host controller.
// Assumes: 10 MHz clock, 100 ns period.
// Notes:   Bus phase lengths are whole clock cycles.
`ifndef NVSRAM_HOST_CFG_SVH
`define NVSRAM_HOST_CFG_SVH
`define ADDR_W          15
`define DATA_W          8
`define CLK_PERIOD_NS   100
`define SETUP_NS        100
`define STROBE_NS       200
`define SAVE_PULSE_NS   500
`define BUSY_WAIT_NS    1000
`define SETUP_CYC       ((`SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_CYC      ((`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SAVE_PULSE_CYC  ((`SAVE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BUSY_WAIT_CYC   ((`BUSY_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W           8
`define CNT_ZERO        8'h00
`define ADDR_ZERO       15'h0000
`define DATA_ZERO       8'h00
`endif

// >>> nvsram_host_pkg.sv
// Purpose: Types for the nonvolatile SRAM host controller.
// Assumes: Constants come from nvsram_host_cfg.svh.
// Notes:   None.
`default_nettype none
package nvsram_host_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_SAVE, ST_BUSY
  } host_state_e;
endpackage
`default_nettype wire

// >>> pin_sync_if.sv
// Purpose: Carries synchronised pin levels between host modules.
// Assumes: Single clock domain.
// Notes:   None.
`include "nvsram_host_cfg.svh"
`default_nettype none
interface pin_sync_if;
  logic [`DATA_W-1:0] data_sync;
  logic               busy_n_sync;
  modport src (output data_sync, output busy_n_sync);
  modport dst (input data_sync, input busy_n_sync);
endinterface
`default_nettype wire

// >>> pin_sync.sv
// Purpose: Two-flop synchronisers for the pins read back from the memory.
// Assumes: Pins are asynchronous to clk_in.
// Notes:   First stage feeds only the second stage.
`include "nvsram_host_cfg.svh"
`default_nettype none
module pin_sync (
  input  wire logic               clk_in,
  input  wire logic               rst_n_in,
  input  wire logic [`DATA_W-1:0] data_pin_in,
  input  wire logic               busy_n_pin_in,
  pin_sync_if.src                 sync_out
);
  logic [`DATA_W:0] meta_ff;
  logic [`DATA_W:0] stab_ff;
  logic [`DATA_W:0] nxt_meta;
  logic [`DATA_W:0] nxt_stab;

  always_comb begin
    nxt_meta = {busy_n_pin_in, data_pin_in};
    nxt_stab = meta_ff;
  end

  // Busy pin idles high, so reset to released
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_ff <= {1'b1, `DATA_ZERO};
      stab_ff <= {1'b1, `DATA_ZERO};
    end else begin
      meta_ff <= nxt_meta;
      stab_ff <= nxt_stab;
    end
  end

  assign sync_out.data_sync   = stab_ff[`DATA_W-1:0];
  assign sync_out.busy_n_sync = stab_ff[`DATA_W];
endmodule
`default_nettype wire

// >>> nvsram_host.sv
// Purpose: Host controller driving a byte-wide nonvolatile SRAM over its pins.
// Assumes: 10 MHz clock; memory timing far faster than one clock period.
// Notes:   One request at a time; software store/recall sequences are not generated.
// Overview of operation
// [RULE_01] Each 15-bit byte address names one of 32,768 byte locations.
// [RULE_02] One two-way 8-bit data bus carries both write and read data.
// [RULE_03] The memory answers only while chip select is low, which the host drives.
// [RULE_04] Write data is stored at the address presented when chip select falls.
// [RULE_05] The memory drives data only while output drive is low.
// [RULE_06] The memory holds the busy pin low for the whole of a save.
// [RULE_07] Pulling the busy pin low starts a save; it idles high by a weak pull-up.
// [RULE_08] The memory saves its whole array on power loss by itself.
// [RULE_09] The memory restores its array at power-up before normal accesses.
// [RULE_10] Save and restore may also be requested under software control; the host only requests saves, via save_req_in, by pulling the busy pin.
// [RULE_11] Write strobe and busy stay high in reads; write strobe is low in writes.
// [RULE_12] Accesses during a save or restore are ignored by the memory.
`include "nvsram_host_cfg.svh"
`default_nettype none
module nvsram_host
  import nvsram_host_pkg::*;
(
  input  wire logic               clk_in,
  input  wire logic               rst_n_in,
  input  wire logic               req_valid_in,
  input  wire logic               req_write_in,
  input  wire logic [`ADDR_W-1:0] req_addr_in,
  input  wire logic [`DATA_W-1:0] req_wdata_in,
  input  wire logic               save_req_in,
  output logic                    req_ready_out,
  output logic                    rsp_valid_out,
  output logic [`DATA_W-1:0]      rsp_rdata_out,
  output logic                    mem_busy_out,
  output logic [`ADDR_W-1:0]      byte_address_out,
  output logic                    chip_select_n_out,
  output logic                    write_strobe_n_out,
  output logic                    output_drive_n_out,
  input  wire logic [`DATA_W-1:0] data_lines_in,
  output logic [`DATA_W-1:0]      data_lines_out,
  output logic                    data_lines_oe_n_out,
  input  wire logic               hw_save_busy_n_in,
  output logic                    hw_save_busy_n_out,
  output logic                    hw_save_busy_n_oe_n_out
);
  pin_sync_if sync_bus ();

  pin_sync u_pin_sync (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .data_pin_in   (data_lines_in),
    .busy_n_pin_in (hw_save_busy_n_in),
    .sync_out      (sync_bus.src)
  );

  host_state_e        state_ff,  nxt_state;
  logic [`CNT_W-1:0]  cnt_ff,    nxt_cnt;
  logic               write_ff,  nxt_write;
  logic [`ADDR_W-1:0] addr_ff,   nxt_addr;
  logic [`DATA_W-1:0] wdata_ff,  nxt_wdata;
  logic [`DATA_W-1:0] rdata_ff,  nxt_rdata;
  logic               rsp_ff,    nxt_rsp;
  logic               cs_n_ff,   nxt_cs_n;
  logic               we_n_ff,   nxt_we_n;
  logic               oe_n_ff,   nxt_oe_n;
  logic               dq_oe_n_ff, nxt_dq_oe_n;
  logic               pull_ff,   nxt_pull;

  function automatic logic [`CNT_W-1:0] cyc(input int n);
    cyc = (n < 1) ? `CNT_W'(1) : `CNT_W'(n);
  endfunction

  // Counter decode shared by the setup, strobe and save phases
  function automatic logic last_cycle(input logic [`CNT_W-1:0] c);
    last_cycle = (c == `CNT_W'(1));
  endfunction

  // Memory busy: restoring after power-up or saving pulls the pin low
  logic mem_busy;
  assign mem_busy = !sync_bus.busy_n_sync;

  always_comb begin
    nxt_state   = state_ff;
    nxt_cnt     = cnt_ff;
    nxt_write   = write_ff;
    nxt_addr    = addr_ff;
    nxt_wdata   = wdata_ff;
    nxt_rdata   = rdata_ff;
    nxt_rsp     = 1'b0;
    nxt_cs_n    = cs_n_ff;
    nxt_we_n    = we_n_ff;
    nxt_oe_n    = oe_n_ff;
    nxt_dq_oe_n = dq_oe_n_ff;
    nxt_pull    = pull_ff;
    case (state_ff)
      ST_IDLE: begin
        nxt_cs_n    = 1'b1;
        nxt_we_n    = 1'b1;
        nxt_oe_n    = 1'b1;
        nxt_dq_oe_n = 1'b1;
        // [RULE_07] Start save by pulling
        if (save_req_in) begin
          // [RULE_10] Save on request
          nxt_pull  = 1'b1;
          nxt_cnt   = cyc(`SAVE_PULSE_CYC);
          nxt_state = ST_SAVE;
        // [RULE_12] Hold accesses while busy
        end else if (req_valid_in && !mem_busy) begin
          nxt_write = req_write_in;
          // [RULE_01] Latch full address
          nxt_addr  = req_addr_in;
          nxt_wdata = req_wdata_in;
          nxt_cnt   = cyc(`SETUP_CYC);
          nxt_state = ST_SETUP;
        end
      end
      ST_SETUP: begin
        // [RULE_04] Address stable before select
        if (last_cycle(cnt_ff)) begin
          // [RULE_03] Select the part
          nxt_cs_n    = 1'b0;
          // [RULE_11] Strobe low only on writes
          nxt_we_n    = !write_ff;
          // [RULE_05] Enable outputs on reads
          nxt_oe_n    = write_ff;
          // [RULE_02] Drive bus on writes
          nxt_dq_oe_n = !write_ff;
          nxt_cnt     = cyc(`STROBE_CYC);
          nxt_state   = ST_STROBE;
        end else begin
          nxt_cnt = cnt_ff - `CNT_W'(1);
        end
      end
      ST_STROBE: begin
        if (last_cycle(cnt_ff)) begin
          nxt_cs_n  = 1'b1;
          nxt_we_n  = 1'b1;
          nxt_oe_n  = 1'b1;
          nxt_state = ST_HOLD;
        end else begin
          nxt_cnt = cnt_ff - `CNT_W'(1);
        end
      end
      ST_HOLD: begin
        // Sync stages now hold data taken while the part still drove it;
        // sampling a cycle earlier would catch the bus before it settled
        if (!write_ff) begin
          nxt_rdata = sync_bus.data_sync;
        end
        // Keep write data one cycle past strobe release for hold time
        nxt_dq_oe_n = 1'b1;
        nxt_rsp     = 1'b1;
        nxt_state   = ST_IDLE;
      end
      ST_SAVE: begin
        if (last_cycle(cnt_ff)) begin
          nxt_pull  = 1'b0;
          nxt_cnt   = cyc(`BUSY_WAIT_CYC);
          nxt_state = ST_BUSY;
        end else begin
          nxt_cnt = cnt_ff - `CNT_W'(1);
        end
      end
      ST_BUSY: begin
        // [RULE_06] Wait for busy release
        if (cnt_ff != `CNT_ZERO) begin
          nxt_cnt = cnt_ff - `CNT_W'(1);
        end else if (!mem_busy) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_ff   <= ST_IDLE;
      cnt_ff     <= `CNT_ZERO;
      write_ff   <= 1'b0;
      addr_ff    <= `ADDR_ZERO;
      wdata_ff   <= `DATA_ZERO;
      rdata_ff   <= `DATA_ZERO;
      rsp_ff     <= 1'b0;
      cs_n_ff    <= 1'b1;
      we_n_ff    <= 1'b1;
      oe_n_ff    <= 1'b1;
      dq_oe_n_ff <= 1'b1;
      pull_ff    <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      cnt_ff     <= nxt_cnt;
      write_ff   <= nxt_write;
      addr_ff    <= nxt_addr;
      wdata_ff   <= nxt_wdata;
      rdata_ff   <= nxt_rdata;
      rsp_ff     <= nxt_rsp;
      cs_n_ff    <= nxt_cs_n;
      we_n_ff    <= nxt_we_n;
      oe_n_ff    <= nxt_oe_n;
      dq_oe_n_ff <= nxt_dq_oe_n;
      pull_ff    <= nxt_pull;
    end
  end

  assign req_ready_out           = (state_ff == ST_IDLE) && !save_req_in && !mem_busy;
  assign rsp_valid_out           = rsp_ff;
  assign rsp_rdata_out           = rdata_ff;
  assign mem_busy_out            = mem_busy;
  assign byte_address_out        = addr_ff;
  assign chip_select_n_out       = cs_n_ff;
  assign write_strobe_n_out      = we_n_ff;
  assign output_drive_n_out      = oe_n_ff;
  assign data_lines_out          = wdata_ff;
  assign data_lines_oe_n_out     = dq_oe_n_ff;
  // Open drain: only ever drive low
  assign hw_save_busy_n_out      = 1'b0;
  assign hw_save_busy_n_oe_n_out = !pull_ff;
endmodule
`default_nettype wire

// >>> nvsram_host_chk.sv
// Purpose: Pin timing assertions for nvsram_host.
// Assumes: One clock domain, async active-low reset.
// Notes:   Bound to the top module by port names.
`include "nvsram_host_cfg.svh"
`default_nettype none
module nvsram_host_chk (
  input wire logic               clk_in,
  input wire logic               rst_n_in,
  input wire logic               req_valid_in,
  input wire logic               req_write_in,
  input wire logic [`ADDR_W-1:0] req_addr_in,
  input wire logic [`DATA_W-1:0] req_wdata_in,
  input wire logic               req_ready_out,
  input wire logic               rsp_valid_out,
  input wire logic               mem_busy_out,
  input wire logic [`ADDR_W-1:0] byte_address_out,
  input wire logic               chip_select_n_out,
  input wire logic               write_strobe_n_out,
  input wire logic               output_drive_n_out,
  input wire logic [`DATA_W-1:0] data_lines_out,
  input wire logic               data_lines_oe_n_out,
  input wire logic               hw_save_busy_n_out,
  input wire logic               hw_save_busy_n_oe_n_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  wire take = req_valid_in && req_ready_out;
  sequence s_rd;
    (!chip_select_n_out && !output_drive_n_out && write_strobe_n_out)[*2];
  endsequence
  sequence s_wr;
    (!chip_select_n_out && !write_strobe_n_out && !data_lines_oe_n_out)[*2];
  endsequence
  a_read_cycle: assert property (take && !req_write_in |=> ##1 s_rd ##1
    (chip_select_n_out && output_drive_n_out) ##1 rsp_valid_out) else $error("read cycle bad");
  a_write_cycle: assert property (take && req_write_in |=> ##1 s_wr ##1
    (chip_select_n_out && write_strobe_n_out) ##1 (rsp_valid_out && data_lines_oe_n_out))
    else $error("write cycle bad");
  a_addr_setup: assert property (take |=> ##1 byte_address_out == $past(req_addr_in, 2))
    else $error("address not presented");
  a_wdata_setup: assert property (take && req_write_in |=> ##1
    data_lines_out == $past(req_wdata_in, 2)) else $error("write data not presented");
  a_cs_gates: assert property (chip_select_n_out |-> write_strobe_n_out && output_drive_n_out)
    else $error("strobe without select");
  a_read_quiet: assert property (!output_drive_n_out |-> hw_save_busy_n_oe_n_out &&
    data_lines_oe_n_out) else $error("host drives during read");
  a_save_pulse: assert property ($fell(hw_save_busy_n_oe_n_out) |->
    (!hw_save_busy_n_oe_n_out)[*5] ##1 hw_save_busy_n_oe_n_out) else $error("save pulse length");
  a_busy_block: assert property (mem_busy_out |-> !req_ready_out)
    else $error("ready while memory busy");
  a_open_drain: assert property (!hw_save_busy_n_oe_n_out |-> !hw_save_busy_n_out)
    else $error("busy pin pulled high");
endmodule
bind nvsram_host nvsram_host_chk u_nvsram_host_chk (.*);
`default_nettype wire

// >>> nvsram_model.sv
// Purpose: Behavioural model of the byte-wide nonvolatile SRAM.
// Assumes: Pins only; no clock.
// Notes:   Released data lines show the inverse of the last value.
`default_nettype none
module nvsram_model #(parameter int SAVE_NS = 1500) (
  input  wire logic [14:0] addr_in,
  input  wire logic        cs_n_in,
  input  wire logic        we_n_in,
  input  wire logic        oe_n_in,
  input  wire logic [7:0]  dq_in,
  input  wire logic        busy_n_in,
  output logic      [7:0]  dq_out,
  output logic             busy_pull_n_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  ram [32768];
  logic [7:0]  nv  [32768];
  logic [14:0] addr_ff;
  logic        saving = 1'b0;
  initial begin
    busy_pull_n_out = 1'b1;
    dq_out = 8'h00;
    for (int i = 0; i < 32768; i++) begin
      nv[i] = i[7:0] ^ 8'h5a;
      ram[i] = nv[i];
    end
  end
  always @* if (cs_n_in) addr_ff = addr_in;
  always @(cs_n_in, we_n_in, dq_in) if (!cs_n_in && !we_n_in && !saving) ram[addr_ff] = dq_in;
  always @(cs_n_in, oe_n_in, we_n_in, saving) begin
    if (!cs_n_in && !oe_n_in && we_n_in && !saving) dq_out = ram[addr_ff];
    else dq_out = ~dq_out;
  end
  // whole array saved on power loss, no host action
  task automatic power_loss();
    for (int i = 0; i < 32768; i++) nv[i] = ram[i];
  endtask
  task automatic power_up();
    for (int i = 0; i < 32768; i++) ram[i] = nv[i];
  endtask
  always @(negedge busy_n_in) if (!saving) begin
    saving = 1'b1;
    busy_pull_n_out = 1'b0;
    for (int i = 0; i < 32768; i++) nv[i] = ram[i];
    #(SAVE_NS);
    busy_pull_n_out = 1'b1;
    saving = 1'b0;
  end
endmodule
`default_nettype wire

// >>> test_nvsram_host.sv
// Purpose: Self-checking bench for nvsram_host with a memory model.
// Assumes: 10 MHz clock, inputs driven on the falling edge.
// Notes:   Busy line is open drain with a pull-up.
`default_nettype none
module test_nvsram_host;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 0, rst_n_in = 0, req_valid_in = 0, req_write_in = 0, save_req_in = 0;
  logic tb_pull_n = 1, req_ready_out, rsp_valid_out, mem_busy_out, chip_select_n_out;
  logic write_strobe_n_out, output_drive_n_out, data_lines_oe_n_out, model_pull_n;
  logic hw_save_busy_n_out, hw_save_busy_n_oe_n_out;
  logic [14:0] req_addr_in = 0, byte_address_out;
  logic [7:0]  req_wdata_in = 0, rsp_rdata_out, data_lines_out, model_dq, q;
  wire  [7:0]  dq = !data_lines_oe_n_out ? data_lines_out : model_dq;
  wire         busy_n = (hw_save_busy_n_oe_n_out || hw_save_busy_n_out) && model_pull_n && tb_pull_n;
  int          mismatches = 0, checks = 0;
  always #50 clk_in = ~clk_in;
  nvsram_host u_nvsram_host (.*, .data_lines_in(dq), .hw_save_busy_n_in(busy_n));
  nvsram_model u_nvsram_model (.addr_in(byte_address_out), .cs_n_in(chip_select_n_out),
    .we_n_in(write_strobe_n_out), .oe_n_in(output_drive_n_out), .dq_in(dq),
    .busy_n_in(busy_n), .dq_out(model_dq), .busy_pull_n_out(model_pull_n));
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Waits on the falling edge until the flag matches, a bounded number of cycles
  task automatic wait_flag(ref logic flag, input logic lvl, input int lim, output int n);
    n = 0;
    while (flag !== lvl && n < lim) begin @(negedge clk_in); n++; end
    if (flag !== lvl) begin check("timeout", 1, 0); print_verdict(); end
  endtask
  task automatic access(input logic wr, input logic [14:0] a, input logic [7:0] d);
    int n;
    @(negedge clk_in);
    {req_valid_in, req_write_in, req_addr_in, req_wdata_in} = {1'b1, wr, a, d};
    wait_flag(req_ready_out, 1'b1, 50, n);
    @(negedge clk_in);
    req_valid_in = 0;
    wait_flag(rsp_valid_out, 1'b1, 20, n);
    check("latency", n, 4);
    q = rsp_rdata_out;
  endtask
  task automatic t_rw();
    logic [14:0] a [4] = '{15'h0000, 15'h7fff, 15'h1234, 15'h4001};
    foreach (a[i]) access(1'b1, a[i], 8'ha5 ^ a[i][7:0]);
    foreach (a[i]) begin
      access(1'b0, a[i], 8'h00);
      check("rdata", q, 8'ha5 ^ a[i][7:0]);
    end
    access(1'b0, 15'h0055, 8'h00);
    check("restored", q, 8'h55 ^ 8'h5a);
    $display("test rw done");
  endtask
  task automatic t_save(input logic by_pin);
    int n;
    access(1'b1, 15'h0100, {7'h61, by_pin});
    @(negedge clk_in);
    if (by_pin) tb_pull_n = 0;
    else save_req_in = 1;
    @(negedge clk_in);
    {tb_pull_n, save_req_in} = 2'b10;
    wait_flag(mem_busy_out, 1'b1, 10, n);
    check("ready busy", req_ready_out, 0);
    check("cs idle", chip_select_n_out, 1);
    wait_flag(mem_busy_out, 1'b0, 60, n);
    check("nv copy", u_nvsram_model.nv[15'h0100], {7'h61, by_pin});
    check("busy long", n > 10, 1);
    access(1'b0, 15'h0100, 8'h00);
    check("after save", q, {7'h61, by_pin});
    $display("test save done");
  endtask
  task automatic t_power();
    access(1'b1, 15'h0200, 8'h3c);
    u_nvsram_model.power_loss();
    check("nv after loss", u_nvsram_model.nv[15'h0200], 8'h3c);
    access(1'b1, 15'h0200, 8'hc3);
    u_nvsram_model.power_up();
    access(1'b0, 15'h0200, 8'h00);
    check("power cycle", q, 8'h3c);
    $display("test power done");
  endtask
  initial begin
    repeat (10) @(negedge clk_in);
    check("cs reset", chip_select_n_out, 1);
    check("dq released", data_lines_oe_n_out, 1);
    rst_n_in = 1;
    t_rw();
    t_save(1'b0);
    t_save(1'b1);
    t_power();
    print_verdict();
  end
endmodule
`default_nettype wire
